//--- common/mag_seq_pkg.sv
// Operation
// - registers and ready pin defined within 0.5 ms of power-up
// - analog chain given 0.5 ms turn-on before any conversion
// - reset restores registers, mux channel, converter sequencer and bias current
// - device is only a bus slave at a 7-bit address, master controls
// - slave port serves standard and fast rates, never high-speed mode
// - master register accesses take priority over measurement activity
// - bias generator on and polarity chosen by measurement-configuration bits
// - continuous mode measures repeatedly at output rate, using config, gain, delay
// - between continuous measurements drop to idle-like state, mode bits unchanged
// - single mode is the power-up default mode
// - single mode measures once, updates outputs, then writes sleep code
// - idle disables converter, amplifier, sensor supply and bias, bus stays usable
// - registers retained in continuous, single and idle modes
// - sleep stops internal clock, only bus listening stays active
// - sleep still executes bus commands without leaving sleep
// - normal measurement: (reading after set minus reading after reset) / 2
// - bias self-test uses offset-strap current, no set/reset differencing
// - normal measurement is the reset-default configuration
// - gain, delay and rate apply alike to every configuration
// - after a reset pulse wait sensor turn-on before sampling
//
// shared constants and types of the magnetometer mode sequencer
// assumes a single 200 MHz core clock and a plain register port
package mag_seq_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int LOGIC_ON_US = 500;          // 0.5 ms
	localparam int ANALOG_ON_US = 500;         // 0.5 ms
	localparam int LOGIC_ON_CYC = LOGIC_ON_US * CLK_MHZ;
	localparam int ANALOG_ON_CYC = ANALOG_ON_US * CLK_MHZ;
	localparam int PULSE_CYC = 20;             // strap pulse width
	localparam int DELAY_STEP_CYC = 200;       // per delay code step
	localparam int GAP_BASE_CYC = 100000;      // gap at fastest rate
	localparam int CNT_W = 24;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_CFG_A = 4'h0;
	localparam logic [3:0] OFS_CFG_B = 4'h1;
	localparam logic [3:0] OFS_MODE = 4'h2;
	localparam logic [3:0] OFS_X_MSB = 4'h3;
	localparam logic [3:0] OFS_X_LSB = 4'h4;
	localparam logic [3:0] OFS_Y_MSB = 4'h5;
	localparam logic [3:0] OFS_Y_LSB = 4'h6;
	localparam logic [3:0] OFS_Z_MSB = 4'h7;
	localparam logic [3:0] OFS_Z_LSB = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'h9;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CFGA_MEAS_LSB = 0;          // meas_config_bits [1:0]
	localparam int CFGA_RATE_LSB = 2;          // rate bits [4:2]
	localparam int CFGB_DELAY_LSB = 0;         // delay_select_bits [2:0]
	localparam int CFGB_GAIN_LSB = 5;          // gain_select_bits [7:5]
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam logic [7:0] CFG_A_RST = 8'h10;  // normal config, rate 4
	localparam logic [7:0] CFG_B_RST = 8'h20;  // gain 1, delay 0

	typedef enum logic [1:0] {
		MODE_CONT = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_IDLE = 2'b10,
		MODE_SLEEP = 2'b11
	} op_mode_t;

	typedef enum logic [1:0] {
		MEAS_NORMAL = 2'b00,
		MEAS_POS_BIAS = 2'b01,
		MEAS_NEG_BIAS = 2'b10,
		MEAS_RSVD = 2'b11
	} meas_cfg_t;

	localparam op_mode_t MODE_RST = MODE_SINGLE;

	// analog front end controls, travel together
	typedef struct packed {
		logic analog_en;       // converter, amplifier, mux
		logic sensor_supply;   // sensor_supply_pin drive
		logic bias_en;
		logic bias_neg;
		logic strap_set;
		logic strap_reset;
	} analog_ctl_t;

	localparam analog_ctl_t ANALOG_OFF = '0;

endpackage

//--- rtl/mag_mode_seq.sv
// mode sequencer, measurement sequencer and register file of the sensor
// results are differenced or biased samples, all axes committed at once
// assumes the bus protocol engine drives the register port on core_clk
// and the converter handshake (adc_start / adc_done) runs on core_clk too
// osc_run only hints; core_clk keeps running so bus access still works
`timescale 1ns/100ps
module mag_mode_seq import mag_seq_pkg::*; #(
	parameter int LOGIC_ON_CYCLES = LOGIC_ON_CYC,
	parameter int ANALOG_ON_CYCLES = ANALOG_ON_CYC,
	parameter int GAP_BASE_CYCLES = GAP_BASE_CYC,
	parameter logic [6:0] BUS_ADDR = 7'h2a   // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic [6:0] slave_addr,
	output logic adc_start,
	output logic [1:0] adc_chan,
	input wire logic adc_done,
	input wire logic [11:0] adc_data,
	output logic [2:0] gain_sel,
	output analog_ctl_t analog_ctl,
	output logic osc_run,
	output logic result_valid_pin
);

	// sequencer states; idle is also the resting state in sleep
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_POR = 4'b0001,
		ST_WARM = 4'b0010,
		ST_SET = 4'b0011,
		ST_SETTLE = 4'b0100,
		ST_CONV = 4'b0101,
		ST_WAIT = 4'b0110,
		ST_RST = 4'b0111,
		ST_COMMIT = 4'b1000,
		ST_GAP = 4'b1001
	} seq_state_t;

	// sequencer state, shared down-counter and axis/phase position
	seq_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [1:0] axis_r;
	logic phase_r;
	// software-visible settings, kept in every mode
	logic [7:0] cfg_a_r;
	logic [7:0] cfg_b_r;
	op_mode_t mode_r;
	// committed results and the raw samples of the current pass
	logic [15:0] out_r [3];
	logic [11:0] set_r [3];
	logic [11:0] rst_r [3];
	logic valid_r;

	// ----------------------------------------
	// decoded settings
	// ----------------------------------------
	meas_cfg_t meas_cfg;
	logic [2:0] rate_code;
	logic [2:0] delay_code;
	logic is_bias;
	logic meas_mode;
	logic commit;
	logic data_rd;
	logic [CNT_W-1:0] settle_cyc;
	logic [CNT_W-1:0] gap_cyc;

	// fields pulled from the configuration registers
	assign meas_cfg = meas_cfg_t'(cfg_a_r[CFGA_MEAS_LSB +: 2]);
	assign rate_code = cfg_a_r[CFGA_RATE_LSB +: 3];
	assign delay_code = cfg_b_r[CFGB_DELAY_LSB +: 3];
	// reserved code falls back to normal measurement
	assign is_bias = (meas_cfg == MEAS_POS_BIAS) || (meas_cfg == MEAS_NEG_BIAS);
	assign meas_mode = (mode_r == MODE_CONT) || (mode_r == MODE_SINGLE);
	// results land only in a cycle without a bus read, never mid-access
	assign commit = (state_r == ST_COMMIT) && !reg_rd;
	// any read of a data register counts as taking the result
	assign data_rd = reg_rd && (reg_addr >= OFS_X_MSB) && (reg_addr <= OFS_Z_LSB);
	// sensor turn-on plus selected extra delay, same for all configs
	assign settle_cyc = CNT_W'(ANALOG_ON_CYCLES) + CNT_W'(delay_code) * CNT_W'(DELAY_STEP_CYC);
	// slower rate codes stretch the gap between measurements
	assign gap_cyc = CNT_W'(GAP_BASE_CYCLES) << (3'h7 - rate_code);

	// ----------------------------------------
	// measurement sequencer
	// ----------------------------------------
	// one pass: warm-up, three axis conversions after a set pulse and three after a reset pulse, or three with bias
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= ST_POR;
			cnt_r <= CNT_W'(LOGIC_ON_CYCLES);
			axis_r <= 2'h0;
			phase_r <= 1'b0;
		end else if (state_r != ST_POR && state_r != ST_IDLE && state_r != ST_COMMIT && !meas_mode) begin
			// idle or sleep written mid-measurement stops everything but a pending commit
			state_r <= ST_IDLE;
			cnt_r <= '0;
			axis_r <= 2'h0;
			phase_r <= 1'b0;
		end else begin
			case (state_r)
				// logic turn-on count, nothing is measured yet
				ST_POR: begin
					if (cnt_r <= CNT_W'(1)) begin
						state_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// resting state; a measuring mode starts a new pass
				ST_IDLE: begin
					if (meas_mode) begin
						state_r <= ST_WARM;
						cnt_r <= CNT_W'(ANALOG_ON_CYCLES);
					end
				end
				// analog chain powering up before any strap pulse
				ST_WARM: begin
					if (cnt_r <= CNT_W'(1)) begin
						phase_r <= 1'b0;
						axis_r <= 2'h0;
						if (is_bias) begin
							// no strap pulses in self-test
							state_r <= ST_SETTLE;
							cnt_r <= settle_cyc;
						end else begin
							state_r <= ST_SET;
							cnt_r <= CNT_W'(PULSE_CYC);
						end
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// strap pulse held for the pulse width
				ST_SET, ST_RST: begin
					if (cnt_r <= CNT_W'(1)) begin
						// wait sensor turn-on after every strap pulse
						state_r <= ST_SETTLE;
						cnt_r <= settle_cyc;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// sensor turn-on plus the selected extra delay
				ST_SETTLE: begin
					if (cnt_r <= CNT_W'(1)) begin
						state_r <= ST_CONV;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// one start pulse per axis
				ST_CONV: begin
					state_r <= ST_WAIT;
				end
				// next axis, then the reset phase unless biased, then commit
				ST_WAIT: begin
					if (adc_done) begin
						if (axis_r != 2'h2) begin
							axis_r <= axis_r + 2'h1;
							state_r <= ST_CONV;
						end else if (!phase_r && !is_bias) begin
							axis_r <= 2'h0;
							phase_r <= 1'b1;
							state_r <= ST_RST;
							cnt_r <= CNT_W'(PULSE_CYC);
						end else begin
							state_r <= ST_COMMIT;
						end
					end
				end
				// held until a cycle without a bus read
				ST_COMMIT: begin
					if (commit) begin
						axis_r <= 2'h0;
						phase_r <= 1'b0;
						if (mode_r == MODE_CONT) begin
							state_r <= ST_GAP;
							cnt_r <= gap_cyc;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				// low-current pause between continuous passes
				ST_GAP: begin
					if (cnt_r <= CNT_W'(1)) begin
						state_r <= ST_WARM;
						cnt_r <= CNT_W'(ANALOG_ON_CYCLES);
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// unused codes recover to idle
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// converter handshake and sample capture
	// ----------------------------------------
	// start pulse one cycle per axis, mux follows the axis counter
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			adc_start <= 1'b0;
			adc_chan <= 2'h0;
		end else begin
			adc_start <= (state_r == ST_CONV);
			// mux channel tracks the axis being converted
			adc_chan <= axis_r;
		end
	end

	// readings after set (or with bias) and after reset
	// a done pulse outside a wait is ignored
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				set_r[i] <= 12'h000;
				rst_r[i] <= 12'h000;
			end
		end else if (state_r == ST_WAIT && adc_done) begin
			if (phase_r) begin
				rst_r[axis_r] <= adc_data;
			end else begin
				set_r[axis_r] <= adc_data;
			end
		end
	end

	// ----------------------------------------
	// output data registers
	// ----------------------------------------
	// all three axes load in one cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				out_r[i] <= 16'h0000;
			end
		end else if (commit) begin
			for (int i = 0; i < 3; i++) begin
				if (is_bias) begin
					out_r[i] <= {{4{set_r[i][11]}}, set_r[i]};
				end else begin
					out_r[i] <= half_diff(set_r[i], rst_r[i]);
				end
			end
		end
	end

	// signed (set - reset) / 2, 13-bit difference keeps the carry
	// sign of the word comes from the difference, not from the set sample
	function automatic logic [15:0] half_diff(input logic [11:0] a, input logic [11:0] b);
		logic [12:0] d;
		d = {a[11], a} - {b[11], b};
		return {{4{d[12]}}, d[12:1]};
	endfunction

	// ready flag: new result sets, data read clears, set wins
	// status reads leave it alone
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			valid_r <= 1'b0;
		end else if (commit) begin
			valid_r <= 1'b1;
		end else if (data_rd) begin
			valid_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// configuration and mode registers
	// ----------------------------------------
	// bus writes served every cycle, in every mode including sleep
	// only reset reloads them, no mode change clears them
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_a_r <= CFG_A_RST;
			cfg_b_r <= CFG_B_RST;
			mode_r <= MODE_RST;
		end else begin
			if (reg_wr && reg_addr == OFS_CFG_A) begin
				cfg_a_r <= reg_wdata;
			end
			if (reg_wr && reg_addr == OFS_CFG_B) begin
				cfg_b_r <= reg_wdata;
			end
			// a master write to the mode register beats the sleep update
			if (reg_wr && reg_addr == OFS_MODE) begin
				mode_r <= op_mode_t'(reg_wdata[1:0]);
			end else if (commit && mode_r == MODE_SINGLE) begin
				mode_r <= MODE_SLEEP;
			end
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	// data one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (reg_addr == OFS_CFG_A) begin
			reg_rdata <= cfg_a_r;
		end else if (reg_addr == OFS_CFG_B) begin
			reg_rdata <= cfg_b_r;
		end else if (reg_addr == OFS_MODE) begin
			reg_rdata <= {6'h00, mode_r};
		end else if (reg_addr == OFS_X_MSB) begin
			reg_rdata <= out_r[0][15:8];
		end else if (reg_addr == OFS_X_LSB) begin
			reg_rdata <= out_r[0][7:0];
		end else if (reg_addr == OFS_Y_MSB) begin
			reg_rdata <= out_r[1][15:8];
		end else if (reg_addr == OFS_Y_LSB) begin
			reg_rdata <= out_r[1][7:0];
		end else if (reg_addr == OFS_Z_MSB) begin
			reg_rdata <= out_r[2][15:8];
		end else if (reg_addr == OFS_Z_LSB) begin
			reg_rdata <= out_r[2][7:0];
		end else if (reg_addr == OFS_STATUS) begin
			// bit 0 new data, bit 1 sequencer busy
			reg_rdata <= 8'h00 | (8'(valid_r) << STAT_VALID_BIT) | (8'(state_r != ST_IDLE) << STAT_BUSY_BIT);
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// analog, strap, clock and pin controls
	// ----------------------------------------
	// front end powered only inside a measurement pass
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			analog_ctl <= ANALOG_OFF;
			gain_sel <= 3'h0;
			osc_run <= 1'b1;
			slave_addr <= 7'h00;
			result_valid_pin <= 1'b0;
		end else begin
			// off in idle, gap and sleep; warm-up through commit on
			analog_ctl.analog_en <= !(state_r inside {ST_POR, ST_IDLE, ST_GAP});
			analog_ctl.sensor_supply <= !(state_r inside {ST_POR, ST_IDLE, ST_GAP});
			analog_ctl.bias_en <= is_bias && !(state_r inside {ST_POR, ST_IDLE, ST_GAP});
			// polarity only shown while the generator is on
			analog_ctl.bias_neg <= (meas_cfg == MEAS_NEG_BIAS) && !(state_r inside {ST_POR, ST_IDLE, ST_GAP});
			// strap drives follow the pulse states one cycle late
			analog_ctl.strap_set <= (state_r == ST_SET);
			analog_ctl.strap_reset <= (state_r == ST_RST);
			// gain follows its bits one cycle late, ungated by state
			gain_sel <= cfg_b_r[CFGB_GAIN_LSB +: 3];
			// timing clock may stop once asleep and idle
			osc_run <= !(mode_r == MODE_SLEEP && state_r == ST_IDLE);
			// fixed 7-bit address for the external slave engine
			// the slave engine runs standard and fast rates only
			slave_addr <= BUS_ADDR;
			result_valid_pin <= valid_r;
		end
	end

endmodule

//--- sim/mag_seq_properties.sv
// assertion checker for the mode sequencer ports
// assumes one core_clk domain with synchronous active-low reset
`timescale 1ns/100ps
module mag_seq_checker import mag_seq_pkg::*; #(
	parameter logic [6:0] BUS_ADDR = 7'h2a // arbitrary value
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [6:0] slave_addr,
	input wire logic adc_start,
	input wire logic [1:0] adc_chan,
	input wire analog_ctl_t analog_ctl,
	input wire logic osc_run
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ----------------
	// sequences
	// ----------------
	sequence s_no_start;
		!adc_start [*8];
	endsequence
	sequence s_chan_held;
		$stable(adc_chan) [*2];
	endsequence
	// ----------------
	// properties
	// ----------------
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside read slot");
	a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h9 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_addr_fixed: assert property ($past(rst_n) |-> slave_addr == BUS_ADDR)
		else $error("slave address wrong");
	a_warm_first: assert property ($rose(analog_ctl.analog_en) |-> s_no_start)
		else $error("conversion before warm-up");
	a_settle_reset: assert property ($fell(analog_ctl.strap_reset) |-> s_no_start)
		else $error("conversion too soon after strap reset");
	a_start_powered: assert property (adc_start |-> analog_ctl.analog_en && analog_ctl.sensor_supply)
		else $error("conversion with analog chain off");
	a_polarity_enable: assert property (analog_ctl.bias_neg |-> analog_ctl.bias_en)
		else $error("bias polarity without bias");
	a_sleep_quiet: assert property (!osc_run |-> analog_ctl == ANALOG_OFF && !adc_start)
		else $error("activity with clock stopped");
	a_chan_steady: assert property (adc_start |=> s_chan_held)
		else $error("channel moved during conversion");
	a_strap_excl: assert property (!(analog_ctl.strap_set && analog_ctl.strap_reset))
		else $error("set and reset pulses overlap");
endmodule

bind mag_mode_seq mag_seq_checker #(.BUS_ADDR(BUS_ADDR)) u_chk (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.slave_addr(slave_addr),
	.adc_start(adc_start),
	.adc_chan(adc_chan),
	.analog_ctl(analog_ctl),
	.osc_run(osc_run)
);

//--- sim/adc_model.sv
// converter model answering the sequencer's start pulses
// assumes the handshake runs on core_clk; strap pulses mark the phase
`timescale 1ns/100ps
module adc_model import mag_seq_pkg::*; (
	input wire logic core_clk,
	input wire logic adc_start,
	input wire logic [1:0] adc_chan,
	input wire analog_ctl_t analog_ctl,
	output logic adc_done,
	output logic [11:0] adc_data
);
	logic set_phase = 1'b0;
	logic slow = 1'b0;
	int wait_cnt = -1;
	initial adc_done = 1'b0;
	initial adc_data = 12'h000;
	// strap phase tracking and alternating quick and slow answers
	always @(posedge core_clk) begin
		if (analog_ctl.strap_set)
			set_phase <= 1'b1;
		if (analog_ctl.strap_reset)
			set_phase <= 1'b0;
		adc_done <= 1'b0;
		adc_data <= ~adc_data; // no stale sample between answers
		if (adc_start) begin
			wait_cnt <= slow ? 9 : 4;
			slow <= !slow;
		end else if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
		end else if (wait_cnt == 0) begin
			wait_cnt <= -1;
			adc_done <= 1'b1;
			if (analog_ctl.bias_en) // emulated field
				adc_data <= (analog_ctl.bias_neg ? 12'hf80 : 12'h080) + 12'(adc_chan);
			else
				adc_data <= set_phase ? 12'h040 + 12'(adc_chan) : 12'h200;
		end
	end
endmodule

//--- sim/tb.sv
// self-checking bench for the mode sequencer
// assumes the converter model on the far side and a 200 MHz clock
`timescale 1ns/100ps
module tb import mag_seq_pkg::*; ;
	localparam logic [6:0] ADDR = 7'h35; // arbitrary value
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [6:0] slave_addr;
	logic adc_start;
	logic adc_done;
	logic [1:0] adc_chan;
	logic [11:0] adc_data;
	logic [2:0] gain_sel;
	analog_ctl_t analog_ctl;
	logic osc_run;
	logic result_valid_pin;
	logic saw_pos = 1'b0;
	logic saw_neg = 1'b0;
	int fails = 0;
	int checked = 0;

	always #2.5 core_clk = ~core_clk;

	mag_mode_seq #(.LOGIC_ON_CYCLES(10), .ANALOG_ON_CYCLES(20), .GAP_BASE_CYCLES(20), .BUS_ADDR(ADDR)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slave_addr(slave_addr),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
		.gain_sel(gain_sel), .analog_ctl(analog_ctl), .osc_run(osc_run),
		.result_valid_pin(result_valid_pin));

	adc_model u_adc (.core_clk(core_clk), .adc_start(adc_start), .adc_chan(adc_chan),
		.analog_ctl(analog_ctl), .adc_done(adc_done), .adc_data(adc_data));

	// bias polarity seen on the bias generator controls
	always @(posedge core_clk) begin
		if (analog_ctl.bias_en && analog_ctl.bias_neg)
			saw_neg <= 1'b1;
		if (analog_ctl.bias_en && !analog_ctl.bias_neg)
			saw_pos <= 1'b1;
	end

	// ----------------
	// helpers
	// ----------------
	task complete_run;
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one clean strobe per access, no glitch on any line
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask
	task wait_valid;
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 400 && s[STAT_VALID_BIT] !== 1'b1; i++)
			rd(OFS_STATUS, s);
		chk({15'h0, s[STAT_VALID_BIT]}, 16'h0001);
	endtask
	// expected axis word: 0 differenced, 1 positive bias, 2 negative bias
	function logic [15:0] exp_axis(input int kind, input int ch);
		int d;
		d = (64 + ch) - 512;
		if (kind == 1)
			return 16'(128 + ch);
		if (kind == 2)
			return 16'(ch - 128);
		return 16'(d >>> 1);
	endfunction
	task rd_axes(input int kind);
		logic [7:0] hi;
		logic [7:0] lo;
		for (int ch = 0; ch < 3; ch++) begin
			rd(4'(3 + 2 * ch), hi);
			rd(4'(4 + 2 * ch), lo);
			chk({hi, lo}, exp_axis(kind, ch));
		end
	endtask

	// ----------------
	// scenarios
	// ----------------
	task t_reset;
		rd_chk(OFS_CFG_A, CFG_A_RST);
		rd_chk(OFS_CFG_B, CFG_B_RST);
		rd_chk(OFS_MODE, 8'h01);
		chk({9'h0, slave_addr}, {9'h0, ADDR});
		chk({15'h0, result_valid_pin}, 16'h0000);
	endtask
	task t_single;
		wait_valid();
		chk({15'h0, result_valid_pin}, 16'h0001);
		rd_axes(0);
		chk({15'h0, result_valid_pin}, 16'h0000);
		rd_chk(OFS_MODE, 8'h03);
		rd_chk(OFS_CFG_A, CFG_A_RST);
	endtask
	task t_bias;
		for (int k = 1; k < 3; k++) begin
			wr(OFS_CFG_A, 8'h10 | 8'(k));
			wr(OFS_MODE, 8'h01);
			wait_valid();
			rd_axes(k);
		end
		chk({14'h0, saw_pos, saw_neg}, 16'h0003);
	endtask
	task t_cont;
		wr(OFS_CFG_A, 8'h1c);
		wr(OFS_MODE, 8'h00);
		wait_valid();
		rd_axes(0);
		wait_valid();
		rd_axes(0);
		rd_chk(OFS_MODE, 8'h00);
		wr(OFS_MODE, 8'h02);
		repeat (100) @(posedge core_clk);
		chk({10'h0, analog_ctl}, 16'h0000);
		rd_chk(OFS_CFG_A, 8'h1c);
	endtask
	task t_sleep;
		wr(OFS_MODE, 8'h03);
		repeat (50) @(posedge core_clk);
		chk({15'h0, osc_run}, 16'h0000);
		wr(OFS_CFG_B, 8'he3);
		rd_chk(OFS_CFG_B, 8'he3);
		rd_chk(OFS_MODE, 8'h03);
		chk({13'h0, gain_sel}, 16'h0007);
	endtask
	task t_refuse;
		rd_chk(4'hf, 8'h00);
		wr(OFS_X_MSB, 8'h55);
		rd_chk(OFS_X_MSB, 8'(exp_axis(0, 0) >> 8));
	endtask

	// watchdog against a hung sequence
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_single();
		t_bias();
		t_cont();
		t_sleep();
		t_refuse();
		complete_run();
	end
endmodule
